// ---- psl_pkg.sv ----
/*
 * Shared constants for the peripheral-side serial link slave.
 * Assumes a 100 MHz system clock sampling a slower master link clock.
 */
package psl_pkg;
   localparam int          BYTE_BITS    = 8;
   localparam int          MAX_PAYLOAD  = 15;
   localparam logic [3:0]  MAX_PAY_CNT  = 4'hF;
   localparam logic [2:0]  BIT_LAST     = 3'h7;
   localparam logic [7:0]  STATUS_RST   = 8'h00;
   localparam logic [7:0]  IDLE_BYTE    = 8'hFF;
   localparam logic [7:0]  CARD_ADDR_RST = 8'h00;

   typedef enum logic [2:0] {
      PSL_IDLE = 3'b001,
      PSL_CMD  = 3'b010,
      PSL_DATA = 3'b100
   } psl_state_e;
endpackage

// ---- psl_slave.sv ----
/*
 * Link-level slave of a peripheral card: select, clock and data from the
 * master are sampled on clk_sys; bytes go to the user through a two-entry
 * buffer, return bytes are loaded from the user side.
 * Assumes the master link clock is far slower than clk_sys (>= 8x).
 */
// Notes on behaviour
// RULE1 - only the master drives the link clock; this block only samples it.
// RULE2 - commands arrive on the master-out line, replies leave on master-in.
// RULE3 - seeing select asserted makes this card selected and act on commands; bytes reach the user only if the first byte matches cardAddr.
// RULE4 - the master asserts select first, then clocks out the command.
// RULE5 - the first byte of each command carries the card address to decode.
// RULE6 - selection is immediate on select, with no wait for a command byte.
// RULE7 - reply bits shift out in the same clocks as command bits shift in.
// RULE8 - the link holds exactly while select is asserted; release ends it.
// RULE9 - a transfer is one register-number byte and 0 to 15 payload bytes.
// RULE10 - a zero-length transfer carries only the register-number byte.
// RULE11 - each transfer returns the status byte of the previous command.
// RULE12 - eight bits a byte, msb first, bit count cleared on deselect.
// RULE13 - link inputs are synchronised; the return line idles deselected.
`timescale 1ns/1ns
module psl_slave
   import psl_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   input  wire logic       linkClk,
   input  wire logic       selectIn_b,
   input  wire logic       dataFromMaster,
   output logic            dataToMaster,
   output logic            dataToMasterOe_b,
   input  wire logic [7:0] cardAddr,
   output logic            selected,
   output logic [7:0]      rxByte,
   output logic            rxFirst,
   output logic            rxValid,
   input  wire logic       rxReady,
   input  wire logic [7:0] txByte,
   input  wire logic [7:0] statusIn,
   input  wire logic       statusLoad,
   output logic            overrun
);
   typedef struct packed {
      logic [2:0] clkSync;
      logic [1:0] selSync;
      logic [1:0] datSync;
      psl_state_e state;
      logic       addrHit;
      logic       regDone;
      logic [2:0] bitCnt;
      logic [3:0] payCnt;
      logic [7:0] shIn;
      logic [7:0] shOut;
      logic [7:0] status;
      logic [7:0] buf0;
      logic       buf0First;
      logic [7:0] buf1;
      logic       buf1First;
      logic [1:0] fill;
      logic       vld;
      logic       doOut;
      logic       doOe_b;
      logic       sel;
      logic       ovr;
   } psl_state_s;

   psl_state_s s_reg;
   psl_state_s s_next;

   localparam psl_state_s S_RST = '{
      clkSync   : 3'h0,
      selSync   : 2'h3, // idle level of the select pin, no false select
      datSync   : 2'h3,
      state     : PSL_IDLE,
      addrHit   : 1'h0,
      regDone   : 1'h0,
      bitCnt    : 3'h0,
      payCnt    : 4'h0,
      shIn      : 8'h00,
      shOut     : IDLE_BYTE,
      status    : STATUS_RST,
      buf0      : 8'h00,
      buf0First : 1'h0,
      buf1      : 8'h00,
      buf1First : 1'h0,
      fill      : 2'h0,
      vld       : 1'h0,
      doOut     : IDLE_BYTE[7],
      doOe_b    : 1'h1,
      sel       : 1'h0,
      ovr       : 1'h0
   };

   logic       riseEdge;
   logic       fallEdge;
   logic       selNow;
   logic [7:0] byteDone;
   logic       pushVal;
   logic       pushFirst;
   logic       pop;

   always_comb begin
      s_next = s_reg;
      // [RULE13] two stages before any logic reads link inputs
      s_next.clkSync = {s_reg.clkSync[1:0], linkClk};
      s_next.selSync = {s_reg.selSync[0], selectIn_b};
      s_next.datSync = {s_reg.datSync[0], dataFromMaster};
      // [RULE1] link clock only sampled, edges found on clk_sys
      riseEdge  = s_reg.clkSync[1] & ~s_reg.clkSync[2];
      fallEdge  = ~s_reg.clkSync[1] & s_reg.clkSync[2];
      selNow    = ~s_reg.selSync[1];
      byteDone  = {s_reg.shIn[6:0], s_reg.datSync[1]};
      pushVal   = 1'b0;
      pushFirst = 1'b0;
      pop       = rxValid & rxReady;
      s_next.sel = selNow; // [RULE6] [RULE3]

      if (statusLoad) begin
         s_next.status = statusIn;
      end

      case (s_reg.state)
         PSL_IDLE: begin
            s_next.doOe_b = 1'b1; // [RULE13]
            s_next.doOut  = IDLE_BYTE[7];
            s_next.bitCnt = 3'h0;
            if (selNow) begin // [RULE4] [RULE6]
               s_next.state  = PSL_CMD;
               // [RULE11] previous command's status goes out first
               s_next.shOut  = s_reg.status;
               s_next.doOut  = s_reg.status[7];
               s_next.doOe_b = 1'b0;
               s_next.payCnt = 4'h0;
               s_next.addrHit = 1'b0;
               s_next.regDone = 1'b0;
            end
         end
         PSL_CMD, PSL_DATA: begin
            if (riseEdge) begin // [RULE7] sample on rising
               s_next.shIn   = byteDone; // [RULE12] msb first
               s_next.bitCnt = s_reg.bitCnt + 3'h1;
               if (s_reg.bitCnt == BIT_LAST) begin
                  if (s_reg.state == PSL_CMD) begin
                     // [RULE5] first byte is the card address
                     s_next.addrHit = (byteDone == cardAddr);
                     s_next.state   = PSL_DATA;
                  end else if (s_reg.addrHit) begin
                     // [RULE9] [RULE10] register byte then <=15 payload
                     if (!s_reg.regDone) begin
                        pushVal        = 1'b1;
                        pushFirst      = 1'b1;
                        s_next.regDone = 1'b1;
                     end else if (s_reg.payCnt != MAX_PAY_CNT) begin
                        // payCnt counts payload only, so 15 fit
                        pushVal       = 1'b1;
                        s_next.payCnt = s_reg.payCnt + 4'h1;
                     end
                  end
               end
            end
            if (fallEdge) begin // [RULE7] [RULE2] drive on falling
               if (s_reg.bitCnt == 3'h0) begin
                  s_next.shOut = txByte;
                  s_next.doOut = txByte[7];
               end else begin
                  s_next.shOut = {s_reg.shOut[6:0], 1'b0};
                  s_next.doOut = s_reg.shOut[6];
               end
            end
            if (!selNow) begin // [RULE8] [RULE12] end of transaction
               s_next.state  = PSL_IDLE;
               s_next.bitCnt = 3'h0;
               s_next.doOe_b = 1'b1;
            end
         end
         default: begin
            s_next.state = PSL_IDLE;
         end
      endcase

      // cleared first, so a drop in the same cycle still sets the flag
      if (selNow && !s_reg.sel) begin
         s_next.ovr = 1'b0;
      end
      // two-entry buffer: stall by receiver loses nothing until both full
      if (pop) begin
         s_next.buf0      = s_reg.buf1;
         s_next.buf0First = s_reg.buf1First;
      end
      if (pushVal && (s_reg.fill == 2'h2) && !pop) begin
         s_next.ovr = 1'b1; // link cannot be stalled, so flag the drop
      end else if (pushVal) begin
         if ((s_reg.fill == 2'h0) || ((s_reg.fill == 2'h1) && pop)) begin
            s_next.buf0      = byteDone;
            s_next.buf0First = pushFirst;
         end else begin
            s_next.buf1      = byteDone;
            s_next.buf1First = pushFirst;
         end
      end
      if (pushVal && !pop && (s_reg.fill != 2'h2)) begin
         s_next.fill = s_reg.fill + 2'h1;
      end else if (pop && !pushVal) begin
         s_next.fill = s_reg.fill - 2'h1;
      end
      // rxValid leaves a flop of its own, not a compare on fill
      s_next.vld = (s_next.fill != 2'h0);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_reg <= S_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign dataToMaster     = s_reg.doOut;
   assign dataToMasterOe_b = s_reg.doOe_b;
   assign selected         = s_reg.sel;
   assign rxByte           = s_reg.buf0;
   assign rxFirst          = s_reg.buf0First;
   assign rxValid          = s_reg.vld;
   assign overrun          = s_reg.ovr;
endmodule

// ---- psl_monitor.sv ----
/* checker for the serial link slave
   bound into psl_slave; one clk_sys domain */
`timescale 1ns/1ns
module psl_monitor (
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic       linkClk,
   input wire logic       selectIn_b,
   input wire logic       dataToMaster,
   input wire logic       dataToMasterOe_b,
   input wire logic       selected,
   input wire logic [7:0] rxByte,
   input wire logic       rxValid,
   input wire logic       rxReady,
   input wire logic       overrun
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_sel_enter:
      assert property (!selectIn_b[*5] |-> selected) else $error("no select");
   a_oe_drive:
      assert property (!selectIn_b[*5] |-> !dataToMasterOe_b) else $error("oe");
   a_sel_leave:
      assert property (selectIn_b[*5] |-> !selected && dataToMasterOe_b)
      else $error("still selected");
   a_rx_hold:
      assert property (rxValid && !rxReady |=> rxValid && $stable(rxByte))
      else $error("head lost");
   a_rx_quiet:
      assert property (selectIn_b[*5] ##0 !rxValid |=> !rxValid)
      else $error("byte while idle");
   a_tx_stable:
      assert property ((linkClk && !selectIn_b)[*5] |=> $stable(dataToMaster))
      else $error("return bit moved");
   a_ovr_clear:
      assert property (overrun && $fell(selectIn_b) |-> ##[1:4] !overrun)
      else $error("overrun kept");
   a_ovr_empty:
      assert property (!rxValid && !overrun |=> !overrun) else $error("ovr");
endmodule
bind psl_slave psl_monitor u_psl_monitor (
   .clk_sys          (clk_sys),
   .rst_b            (rst_b),
   .linkClk          (linkClk),
   .selectIn_b       (selectIn_b),
   .dataToMaster     (dataToMaster),
   .dataToMasterOe_b (dataToMasterOe_b),
   .selected         (selected),
   .rxByte           (rxByte),
   .rxValid          (rxValid),
   .rxReady          (rxReady),
   .overrun          (overrun)
);

// ---- psl_master_model.sv ----
/* master side of the link: sources clock, select and command bits
   frames are started by the bench through the frame task */
`timescale 1ns/1ns
module psl_master_model (
   output logic      linkClk,
   output logic      selectIn_b,
   output logic      dataFromMaster,
   input  wire logic dataToMaster,
   input  wire logic dataToMasterOe_b
);
   logic lineIn;
   // an undriven return line reads inverted, so a late enable shows up
   assign lineIn = dataToMasterOe_b ? ~dataToMaster : dataToMaster;
   initial begin
      linkClk = 0;
      selectIn_b = 1;
      dataFromMaster = 1;
   end
   task automatic frame(input logic [7:0] q[$], output logic [7:0] r[$]);
      r = {};
      #3;
      selectIn_b = 0;
      #160;
      foreach (q[i]) begin
         r.push_back(8'h00);
         for (int b = 7; b >= 0; b--) begin
            dataFromMaster = q[i][b];
            #80 r[i][b] = lineIn;
            linkClk = 1;
            #80 linkClk = 0;
         end
      end
      #80 selectIn_b = 1;
      dataFromMaster = ~dataFromMaster; // released line keeps no value
   endtask
endmodule

// ---- tb.sv ----
/* bench for psl_slave driven through the master model
   expects the checker to be bound in */
`timescale 1ns/1ns
module tb;
   localparam logic [7:0] ADDR = 8'h2D;
   logic       clk_sys, rst_b, rxReady, statusLoad, linkClk, selectIn_b;
   logic       dataFromMaster, dataToMaster, dataToMasterOe_b, selected;
   logic       rxFirst, rxValid, overrun;
   logic [7:0] txByte, statusIn, rxByte;
   logic [7:0] r[$];
   logic [7:0] idleView;
   int         failures, check_count;
   psl_slave u_psl_slave (
      .clk_sys          (clk_sys),
      .rst_b            (rst_b),
      .linkClk          (linkClk),
      .selectIn_b       (selectIn_b),
      .dataFromMaster   (dataFromMaster),
      .dataToMaster     (dataToMaster),
      .dataToMasterOe_b (dataToMasterOe_b),
      .cardAddr         (ADDR),
      .selected         (selected),
      .rxByte           (rxByte),
      .rxFirst          (rxFirst),
      .rxValid          (rxValid),
      .rxReady          (rxReady),
      .txByte           (txByte),
      .statusIn         (statusIn),
      .statusLoad       (statusLoad),
      .overrun          (overrun)
   );
   psl_master_model u_psl_master_model (
      .linkClk          (linkClk),
      .selectIn_b       (selectIn_b),
      .dataFromMaster   (dataFromMaster),
      .dataToMaster     (dataToMaster),
      .dataToMasterOe_b (dataToMasterOe_b)
   );
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic conclude;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic load(input logic [7:0] s);
      @(posedge clk_sys);
      statusIn <= s;
      statusLoad <= 1;
      @(posedge clk_sys);
      statusLoad <= 0;
   endtask
   task automatic pop(input logic [7:0] exp, input logic first);
      int n;
      n = 0;
      while (rxValid !== 1'h1 && n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 400) begin
         failures++;
         conclude();
      end else begin
         chk(rxByte, exp);
         chk({7'h0, rxFirst}, {7'h0, first});
         @(posedge clk_sys) rxReady <= 1;
         @(posedge clk_sys) rxReady <= 0;
         @(negedge clk_sys);
      end
   endtask
   task automatic t_write;
      load(8'h5A);
      u_psl_master_model.frame({ADDR, 8'h21, 8'hC3}, r);
      chk(r[0], 8'h5A);
      chk(r[1], 8'h96);
      pop(8'h21, 1'h1);
      pop(8'hC3, 1'h0);
      $display("t_write done");
   endtask
   task automatic t_overrun;
      u_psl_master_model.frame({ADDR, 8'h01, 8'h02, 8'h03}, r);
      chk({7'h0, overrun}, 8'h01);
      pop(8'h01, 1'h1);
      pop(8'h02, 1'h0);
      chk({7'h0, rxValid}, 8'h00);
      $display("t_overrun done");
   endtask
   task automatic t_zero;
      load(8'hA5);
      u_psl_master_model.frame({ADDR, 8'h3C}, r);
      chk(r[0], 8'hA5);
      chk({7'h0, overrun}, 8'h00);
      pop(8'h3C, 1'h1);
      chk({7'h0, rxValid}, 8'h00);
      $display("t_zero done");
   endtask
   task automatic t_long;
      logic [7:0] q[$];
      q = {ADDR, 8'h40};
      for (int i = 1; i <= 16; i++) begin
         q.push_back(8'(i));
      end
      fork
         u_psl_master_model.frame(q, r);
         begin
            pop(8'h40, 1'h1);
            for (int i = 1; i <= 15; i++) begin
               pop(8'(i), 1'h0);
            end
         end
      join
      chk(r[0], 8'hA5);
      chk({7'h0, rxValid}, 8'h00);
      chk({7'h0, overrun}, 8'h00);
      $display("t_long done");
   endtask
   task automatic t_foreign;
      u_psl_master_model.frame({ADDR ^ 8'h01, 8'h11}, r);
      chk({7'h0, rxValid}, 8'h00);
      chk(r[0], 8'hA5);
      $display("t_foreign done");
   endtask
   initial begin
      {rst_b, rxReady, statusLoad, statusIn} = 0;
      txByte = 8'h96;
      repeat (8) @(posedge clk_sys);
      rst_b <= 1;
      @(negedge clk_sys);
      idleView = {4'h0, selected, dataToMasterOe_b, dataToMaster, rxValid};
      chk(idleView, 8'h06);
      t_write;
      t_overrun;
      t_zero;
      t_long;
      t_foreign;
      conclude;
   end
endmodule
